// ===== verilog/relay_combiner_pkg.sv
// Constants, register map and carrier types for the relay output combiner.
// Assumes a 250 MHz system clock and a 10 ms timer resolution.
package relay_combiner_pkg;
    localparam int unsigned SLOTS         = 7;
    localparam int unsigned TIME_W        = 15;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned DATA_W        = 32;
    // Timebase: settings count in 10 ms units, 0.00 .. 300.00 s
    localparam int unsigned CLOCK_PERIOD_NS = 4;
    localparam int unsigned TICK_PERIOD_NS  = 10_000_000;
    localparam int unsigned TICK_CYCLES     = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
    localparam logic [TIME_W-1:0] TIME_MAX  = 15'h7530; // 300.00 s
    // Register byte addresses
    localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
    localparam logic [ADDR_W-1:0] HOLD_ADDR   = 8'h04;
    localparam logic [ADDR_W-1:0] OFFDLY_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h0C;
    // Control field positions
    localparam int unsigned SLOT_EN_LSB  = 0;
    localparam int unsigned SLOT_INV_LSB = 8;
    localparam int unsigned COLL_INV_BIT = 16;
    localparam int unsigned LATCH_BIT    = 17;
    localparam int unsigned CLOSED_BIT   = 18;
    localparam int unsigned ACK_EN_BIT   = 19;
    // Reset values: nothing assigned, no inversion, working-current
    localparam logic [SLOTS-1:0]  SLOT_EN_RST  = 7'h00;
    localparam logic [SLOTS-1:0]  SLOT_INV_RST = 7'h00;
    localparam logic [TIME_W-1:0] TIME_RST     = 15'h0000;

    typedef struct packed {
        logic             ack_en;
        logic             closed;
        logic             latched;
        logic             coll_inv;
        logic [SLOTS-1:0] slot_inv;
        logic [SLOTS-1:0] slot_en;
    } ctrl_t;

    localparam ctrl_t CTRL_RST = '{ack_en: 1'b0, closed: 1'b0,
        latched: 1'b0, coll_inv: 1'b0, slot_inv: SLOT_INV_RST,
        slot_en: SLOT_EN_RST};

    typedef struct packed {
        logic addr_ok;
        logic wr;
        logic rd;
    } bus_t;

    typedef enum logic [2:0] {
        ST_OFF  = 3'h1,
        ST_ON   = 3'h2,
        ST_WAIT = 3'h4
    } relay_state_t;
endpackage : relay_combiner_pkg

// ===== verilog/tick_timer.sv
// Down counter of timebase ticks, busy while time remains.
// Assumes tick is a one-cycle pulse from the same clock.
`timescale 1ns/1ns
`default_nettype none
module tick_timer
    import relay_combiner_pkg::*;
(
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              ce,
    input  wire logic              tick,
    input  wire logic              load,
    input  wire logic [TIME_W-1:0] value,
    output logic                   busy
);
    logic [TIME_W:0] count_q;

    // One extra tick so a partial first tick never shortens the time
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            count_q <= '0;
        end else if (ce) begin
            if (load) begin
                count_q <= (value == '0) ? '0 : {1'b0, value} + 16'h0001;
            end else if (tick && count_q != '0) begin
                count_q <= count_q - 16'h0001;
            end
        end
    end

    assign busy = (count_q != '0);
endmodule : tick_timer
`default_nettype wire

// ===== verilog/relay_output_combiner.sv
// One relay output channel: slot combiner, hold, off delay, latch, mode.
// Assumes slot and acknowledge signals come from logic on this clock.
`timescale 1ns/1ns
`default_nettype none
module relay_output_combiner
    import relay_combiner_pkg::*;
#(
    parameter int unsigned TICK_LEN = TICK_CYCLES
)
(
    input  wire logic              clock,
    input  wire logic              resetn,
    input  wire logic              ce,
    input  wire logic [SLOTS-1:0]  slot_in,
    input  wire logic              ack_in,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rdata,
    output logic                   relay_coil,
    output logic                   relay_output_channel
);
    ctrl_t             ctrl_q;
    logic [TIME_W-1:0] hold_q;
    logic [TIME_W-1:0] offdly_q;
    logic [DATA_W-1:0] rdata_q;
    logic [31:0]       presc_q;
    logic              tick_q;
    relay_state_t      state_q;
    relay_state_t      state_d;
    logic              latch_q;
    logic              coil_q;
    logic              active_q;
    logic              drive;
    logic              ack_eff;
    logic              demand;
    logic              pickup;
    logic              hold_busy;
    logic              off_busy;
    logic              hold_load;
    logic              off_load;
    logic              active_d;

    // Combiner: per-slot invert, then slot mask, then collective invert
    assign drive = (|(ctrl_q.slot_en
                      & (slot_in ^ ctrl_q.slot_inv)))
                   ^ ctrl_q.coll_inv;
    assign ack_eff = ack_in & ctrl_q.ack_en & ctrl_q.latched;
    assign demand  = drive | latch_q;

    // Register writes; times above 300.00 s are clipped
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ctrl_q   <= CTRL_RST;
            hold_q   <= TIME_RST;
            offdly_q <= TIME_RST;
        end else if (ce && wr_stb) begin
            if (addr == CTRL_ADDR) begin
                ctrl_q.slot_en  <= wdata[SLOT_EN_LSB +: SLOTS];
                ctrl_q.slot_inv <= wdata[SLOT_INV_LSB +: SLOTS];
                ctrl_q.coll_inv <= wdata[COLL_INV_BIT];
                ctrl_q.latched  <= wdata[LATCH_BIT];
                ctrl_q.closed   <= wdata[CLOSED_BIT];
                ctrl_q.ack_en   <= wdata[ACK_EN_BIT];
            end else if (addr == HOLD_ADDR) begin
                hold_q <= (wdata[TIME_W-1:0] > TIME_MAX) ? TIME_MAX
                                                         : wdata[TIME_W-1:0];
            end else if (addr == OFFDLY_ADDR) begin
                offdly_q <= (wdata[TIME_W-1:0] > TIME_MAX) ? TIME_MAX
                                                           : wdata[TIME_W-1:0];
            end
        end
    end

    // Read data stands in the cycle after the strobe only
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (ce) begin
            rdata_q <= '0;
            if (rd_stb) begin
                if (addr == CTRL_ADDR) begin
                    rdata_q <= 32'(ctrl_q.ack_en) << ACK_EN_BIT
                             | 32'(ctrl_q.closed) << CLOSED_BIT
                             | 32'(ctrl_q.latched) << LATCH_BIT
                             | 32'(ctrl_q.coll_inv) << COLL_INV_BIT
                             | 32'(ctrl_q.slot_inv) << SLOT_INV_LSB
                             | 32'(ctrl_q.slot_en) << SLOT_EN_LSB;
                end else if (addr == HOLD_ADDR) begin
                    rdata_q <= 32'(hold_q);
                end else if (addr == OFFDLY_ADDR) begin
                    rdata_q <= 32'(offdly_q);
                end else if (addr == STATUS_ADDR) begin
                    rdata_q <= {26'h0, coil_q, off_busy, hold_busy,
                                latch_q, active_q, drive};
                end
            end
        end
    end

    // Timebase prescaler; a shorter length speeds up simulation
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            presc_q <= '0;
            tick_q  <= 1'b0;
        end else if (ce) begin
            tick_q <= (presc_q == TICK_LEN - 1);
            if (presc_q == TICK_LEN - 1) begin
                presc_q <= '0;
            end else begin
                presc_q <= presc_q + 32'h0000_0001;
            end
        end
    end

    // Output state machine; changes wait for the hold timer
    always_comb begin
        state_d  = state_q;
        off_load = 1'b0;
        case (state_q)
            ST_OFF: begin
                if (demand && !hold_busy) begin
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
                if (!demand) begin
                    if (offdly_q != '0) begin
                        state_d  = ST_WAIT;
                        off_load = 1'b1;
                    end else if (!hold_busy) begin
                        state_d = ST_OFF;
                    end
                end
            end
            ST_WAIT: begin
                if (demand) begin
                    state_d = ST_ON;
                end else if (!off_busy && !hold_busy) begin
                    state_d = ST_OFF;
                end
            end
            default: state_d = ST_OFF;
        endcase
    end

    assign active_d  = (state_d != ST_OFF);
    assign pickup    = (state_q == ST_OFF) && (state_d == ST_ON);
    assign hold_load = (active_d != active_q);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q  <= ST_OFF;
            active_q <= 1'b0;
        end else if (ce) begin
            state_q  <= state_d;
            active_q <= active_d;
        end
    end

    // Latch: pickup sets, acknowledge clears, set wins
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            latch_q <= 1'b0;
        end else if (ce) begin
            if (pickup && ctrl_q.latched) begin
                latch_q <= 1'b1;
            end else if (ack_eff || !ctrl_q.latched) begin
                latch_q <= 1'b0;
            end
        end
    end

    // Coil polarity follows the operating principle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            coil_q <= 1'b0;
        end else if (ce) begin
            coil_q <= active_d ^ ctrl_q.closed;
        end
    end

    tick_timer u_hold (
        .clock  (clock),
        .resetn (resetn),
        .ce     (ce),
        .tick   (tick_q),
        .load   (hold_load),
        .value  (hold_q),
        .busy   (hold_busy)
    );

    tick_timer u_off (
        .clock  (clock),
        .resetn (resetn),
        .ce     (ce),
        .tick   (tick_q),
        .load   (off_load),
        .value  (offdly_q),
        .busy   (off_busy)
    );

    assign rdata                = rdata_q;
    assign relay_coil           = coil_q;
    assign relay_output_channel = active_q;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    property p_or_none;
        (ctrl_q.slot_en == '0) && !ctrl_q.coll_inv |-> !drive;
    endproperty
    a_or_none: assert property (p_or_none)
        else $error("idle slots drove");

    property p_and_form;
        ctrl_q.coll_inv
        && ((ctrl_q.slot_en & (slot_in ^ ctrl_q.slot_inv)) == '0)
        |-> drive;
    endproperty
    a_and_form: assert property (p_and_form)
        else $error("invert lost");

    property p_inv_default;
        $rose(resetn) |-> ctrl_q.slot_inv == SLOT_INV_RST;
    endproperty
    a_inv_default: assert property (p_inv_default)
        else $error("inv default");

    property p_hold;
        ce && $changed(active_q) && hold_q != '0 |=> $stable(active_q);
    endproperty
    a_hold: assert property (p_hold) else $error("hold violated");

    property p_latch_keep;
        latch_q && !ack_eff && ctrl_q.latched |=> latch_q && active_q;
    endproperty
    a_latch_keep: assert property (p_latch_keep)
        else $error("latch lost");

    property p_ack;
        ce && latch_q && ack_eff && !pickup |=> !latch_q;
    endproperty
    a_ack: assert property (p_ack) else $error("ack ignored");

    // Clearing latching empties the latch one enabled edge later
    property p_ack_ignored;
        ce && !ctrl_q.latched |-> !ack_eff ##1 !latch_q;
    endproperty
    a_ack_ignored: assert property (p_ack_ignored)
        else $error("ack effective");

    property p_mode_default;
        $rose(resetn) |-> !ctrl_q.closed;
    endproperty
    a_mode_default: assert property (p_mode_default)
        else $error("mode default");

    property p_off_delay;
        ce && state_q == ST_ON && !demand && offdly_q != '0
        |=> active_q ##1 active_q;
    endproperty
    a_off_delay: assert property (p_off_delay)
        else $error("no off delay");

    property p_coil;
        $past(ce) |-> coil_q == (active_q ^ $past(ctrl_q.closed));
    endproperty
    a_coil: assert property (p_coil) else $error("coil polarity");

    c_pickup: cover property (pickup);
    c_ack_release: cover property (latch_q && ack_eff ##1 !latch_q);
    c_off_wait: cover property (state_q == ST_WAIT ##[1:20] state_q == ST_OFF);
endmodule : relay_output_combiner
`default_nettype wire

// ===== test/relay_coil_model.sv
// Behavioural relay coil and contact set for the output channel.
// Assumes coil drive is registered on the system clock.
`timescale 1ns/1ns
`default_nettype none
module relay_coil_model #(
    parameter int unsigned PICK_CYCLES = 2
)
(
    input  wire logic clock,
    input  wire logic resetn,
    input  wire logic coil,
    output logic      contact
);
    logic [7:0] cnt_q;
    // Armature lags the coil; a blip shorter than pickup never moves it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cnt_q   <= 8'h00;
            contact <= 1'b0;
        end else if (coil == contact) begin
            cnt_q <= 8'h00;
        end else if (cnt_q == 8'(PICK_CYCLES - 1)) begin
            cnt_q   <= 8'h00;
            contact <= coil;
        end else begin
            cnt_q <= cnt_q + 8'h01;
        end
    end
endmodule : relay_coil_model
`default_nettype wire

// ===== test/relay_output_combiner_tb.sv
// Self-checking bench for one relay output channel with coil model.
// Assumes a 10-cycle timebase tick so second-range timers stay short.
`timescale 1ns/1ns
`default_nettype none
module relay_output_combiner_tb;
    import relay_combiner_pkg::*;
    localparam int unsigned TL = 10;
    typedef struct {
        logic [6:0] en, inv, s;
        logic       ci, cl, ch, coil;
    } row_t;
    logic              clock, resetn, ack_in, wr_stb, rd_stb, coil, chan;
    logic              contact, ce;
    logic [SLOTS-1:0]  slot_in;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    int                fail_count, cmp_count, n;
    row_t              rows [8];

    relay_output_combiner #(.TICK_LEN(TL)) DUT (.clock(clock),
        .resetn(resetn), .ce(ce), .slot_in(slot_in), .ack_in(ack_in),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .relay_coil(coil), .relay_output_channel(chan));
    relay_coil_model coil_model (.clock(clock), .resetn(resetn),
        .coil(coil), .contact(contact));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Verdict in one place, also reached by any expired wait
    task automatic finish_test();
        if (fail_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        addr   <= a;
        wdata  <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1 chk("rdata", exp, rdata);
    endtask : rd

    function automatic logic [31:0] mk(logic [6:0] en, inv,
                                       logic ci, lat, cl, ack);
        return {12'h000, ack, cl, lat, ci, 1'b0, inv, 1'b0, en};
    endfunction : mk

    // Cycles until the channel shows v, bounded so a hang ends the run
    task automatic wait_chan(input logic v, output int cnt);
        cnt = 0;
        while (chan !== v) begin
            @(posedge clock);
            #1 cnt++;
            if (cnt > 200) begin
                fail_count++;
                finish_test();
            end
        end
    endtask : wait_chan

    task automatic pulse_slot();
        @(posedge clock);
        slot_in <= 7'h01;
        wait_chan(1'b1, n);
        @(posedge clock);
        slot_in <= 7'h00;
        wait_chan(1'b0, n);
    endtask : pulse_slot

    initial begin
        fail_count = 0;
        cmp_count  = 0;
        resetn = 1'b0;
        {ack_in, wr_stb, rd_stb} = 3'h0;
        ce      = 1'b1;
        slot_in = 7'h00;
        addr    = 8'h00;
        wdata   = 32'h0;
        rows[0] = '{7'h01, 7'h00, 7'h01, 1'b0, 1'b0, 1'b1, 1'b1};
        rows[1] = '{7'h01, 7'h00, 7'h7E, 1'b0, 1'b0, 1'b0, 1'b0};
        rows[2] = '{7'h7F, 7'h00, 7'h40, 1'b0, 1'b0, 1'b1, 1'b1};
        rows[3] = '{7'h03, 7'h01, 7'h00, 1'b0, 1'b0, 1'b1, 1'b1};
        rows[4] = '{7'h03, 7'h00, 7'h00, 1'b1, 1'b0, 1'b1, 1'b1};
        rows[5] = '{7'h03, 7'h03, 7'h01, 1'b1, 1'b0, 1'b0, 1'b0};
        rows[6] = '{7'h03, 7'h03, 7'h03, 1'b1, 1'b0, 1'b1, 1'b1};
        rows[7] = '{7'h01, 7'h00, 7'h00, 1'b0, 1'b1, 1'b0, 1'b1};
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        // Reset state: working-current, no assignment, timers zero
        rd(CTRL_ADDR, 32'h0);
        rd(HOLD_ADDR, 32'h0);
        rd(OFFDLY_ADDR, 32'h0);
        rd(8'h10, 32'h0);
        chk("coil", 1'b0, coil);
        // Combiner table, timers at zero
        foreach (rows[i]) begin
            wr(CTRL_ADDR, mk(rows[i].en, rows[i].inv, rows[i].ci, 1'b0,
                             rows[i].cl, 1'b0));
            rd(CTRL_ADDR, mk(rows[i].en, rows[i].inv, rows[i].ci, 1'b0,
                             rows[i].cl, 1'b0));
            slot_in <= rows[i].s;
            repeat (4) @(posedge clock);
            #1 chk("chan", rows[i].ch, chan);
            chk("coil", rows[i].coil, coil);
            chk("contact", rows[i].coil, contact);
        end
        // Closed-circuit pickup drops the coil
        slot_in <= 7'h01;
        repeat (3) @(posedge clock);
        #1 chk("coil", 1'b0, coil);
        slot_in <= 7'h00;
        wr(CTRL_ADDR, mk(7'h01, 7'h00, 1'b0, 1'b0, 1'b0, 1'b0));
        // Hold of 3 ticks keeps a two-cycle pickup for 30..40 cycles
        wr(HOLD_ADDR, 32'h3);
        pulse_slot();
        chk("hold", 1'b1, n >= 3 * TL - 2 && n <= 4 * TL + 3);
        wr(HOLD_ADDR, 32'h0);
        wr(OFFDLY_ADDR, 32'h2);
        pulse_slot();
        chk("offdly", 1'b1, n >= 2 * TL - 2 && n <= 3 * TL + 3);
        wr(OFFDLY_ADDR, 32'h0);
        // Latched pickup survives drive loss until acknowledged
        wr(CTRL_ADDR, mk(7'h01, 7'h00, 1'b0, 1'b1, 1'b0, 1'b1));
        @(posedge clock);
        slot_in <= 7'h01;
        repeat (3) @(posedge clock);
        slot_in <= 7'h00;
        repeat (10) @(posedge clock);
        #1 chk("latch", 1'b1, chan);
        @(posedge clock);
        ack_in <= 1'b1;
        @(posedge clock);
        ack_in <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("ack", 1'b0, chan);
        // Without an assigned acknowledge the latch stays picked up
        wr(CTRL_ADDR, mk(7'h01, 7'h00, 1'b0, 1'b1, 1'b0, 1'b0));
        slot_in <= 7'h01;
        repeat (3) @(posedge clock);
        slot_in <= 7'h00;
        ack_in  <= 1'b1;
        @(posedge clock);
        ack_in <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("ack_off", 1'b1, chan);
        // Status: coil, active and latch set, drive and timers idle
        rd(STATUS_ADDR, 32'h26);
        // Acknowledge without latching leaves an active channel alone
        wr(CTRL_ADDR, mk(7'h01, 7'h00, 1'b0, 1'b0, 1'b0, 1'b1));
        slot_in <= 7'h01;
        repeat (3) @(posedge clock);
        ack_in <= 1'b1;
        @(posedge clock);
        ack_in <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("noack", 1'b1, chan);
        // Clock enable low freezes the channel despite a dropped slot
        ce      <= 1'b0;
        slot_in <= 7'h00;
        repeat (5) @(posedge clock);
        #1 chk("freeze", 1'b1, chan);
        ce <= 1'b1;
        repeat (3) @(posedge clock);
        #1 chk("thaw", 1'b0, chan);
        // Reset in mid-run drops an active channel at once
        slot_in <= 7'h01;
        repeat (3) @(posedge clock);
        #1 chk("rearm", 1'b1, chan);
        @(posedge clock);
        resetn <= 1'b0;
        #1 chk("rst_chan", 1'b0, chan);
        chk("rst_coil", 1'b0, coil);
        @(posedge clock);
        resetn <= 1'b1;
        rd(CTRL_ADDR, 32'h0);
        chk("rst_idle", 1'b0, chan);
        finish_test();
    end
endmodule : relay_output_combiner_tb
`default_nettype wire
